// ===== design/dcs_cfg.svh
// Purpose: constants for the drive command source select block
// Assumes: included by bare name from design files
// Notes:   offsets are byte addresses on the register bus
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH

// register byte offsets
`define DCS_OFF_CTRL      8'h00
`define DCS_OFF_MODE      8'h04
`define DCS_OFF_ADDR      8'h08
`define DCS_OFF_RATE      8'h0c
`define DCS_OFF_PROT      8'h10
`define DCS_OFF_STAT      8'h14

// control word bit positions (active low commands)
`define DCS_CW_DCBRAKE    2
`define DCS_CW_COAST      3
`define DCS_CW_QSTOP      4

// mode register field positions, two bits each
`define DCS_MODE_COAST    0
`define DCS_MODE_QSTOP    2
`define DCS_MODE_DCBRAKE  4

// reset values
`define DCS_RST_CTRL      16'h0000
`define DCS_RST_MODE      2'h3
`define DCS_RST_ADDR      8'h01
`define DCS_RST_RATE      3'h5
`define DCS_RST_PROT      2'h0

// station address limits per protocol
`define DCS_NATIVE_MIN    8'h00
`define DCS_NATIVE_MAX    8'hf7
`define DCS_BA_MIN        8'h01
`define DCS_BA_MAX        8'hff
`define DCS_MB_MIN        8'h01
`define DCS_MB_MAX        8'hf7

// highest legal line rate code
`define DCS_RATE_MAX      3'h5

// local operating unit setting selectors
`define DCS_PSEL_ADDR     2'h0
`define DCS_PSEL_RATE     2'h1
`define DCS_PSEL_PROT     2'h2

// axi response codes
`define DCS_RESP_OKAY     2'h0
`define DCS_RESP_SLVERR   2'h2

`endif

// ===== design/dcs_pkg.sv
// Purpose: types for the drive command source select block
// Assumes: constants live in dcs_cfg.svh
// Notes:   none
package dcs_pkg;

  // command source selection
  typedef enum logic [1:0] {
    DCS_SRC_DIGITAL = 2'b00,
    DCS_SRC_SERIAL  = 2'b01,
    DCS_SRC_AND     = 2'b10,
    DCS_SRC_OR      = 2'b11
  } dcs_src_e;

  // network protocol, code 2 is not used
  typedef enum logic [1:0] {
    DCS_PROT_NATIVE = 2'b00,
    DCS_PROT_BA     = 2'b01,
    DCS_PROT_UNUSED = 2'b10,
    DCS_PROT_MODBUS = 2'b11
  } dcs_prot_e;

  // line rate codes
  typedef enum logic [2:0] {
    DCS_RATE_300  = 3'b000,
    DCS_RATE_600  = 3'b001,
    DCS_RATE_1200 = 3'b010,
    DCS_RATE_2400 = 3'b011,
    DCS_RATE_4800 = 3'b100,
    DCS_RATE_9600 = 3'b101
  } dcs_rate_e;

endpackage

// ===== design/dcs_sync.sv
// Purpose: two flip-flop synchroniser per bit for terminal inputs
// Assumes: inputs are asynchronous to aclk
// Notes:   first stage feeds only the second stage
module dcs_sync #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // async in, synced out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // idle level is high so no command is requested at reset
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_reg;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_reg    <= 1'b1;
        sync_out[i] <= 1'b1;
      end else begin
        meta_reg    <= async_in[i];
        sync_out[i] <= meta_reg;
      end
    end
  end

endmodule

// ===== design/dcs_merge.sv
// Purpose: merge one local input and one serial bit into a command
// Assumes: both sources active low, input already synchronised
// Notes:   output is registered, request active high
module dcs_merge (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // sources and mode
  input  wire dcs_pkg::dcs_src_e   mode,
  input  wire logic                din_n,
  input  wire logic                ser_n,
  // merged request
  output logic                     req
);

  logic req_next;

  // a 0 on a source means it asks for the command
  always_comb begin
    unique case (mode)
      dcs_pkg::DCS_SRC_DIGITAL: req_next = ~din_n;
      dcs_pkg::DCS_SRC_SERIAL:  req_next = ~ser_n;
      dcs_pkg::DCS_SRC_AND:     req_next = ~din_n & ~ser_n;
      dcs_pkg::DCS_SRC_OR:      req_next = ~din_n | ~ser_n;
    endcase
  end

  // registered to keep the command free of glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req <= 1'b0;
    end else begin
      req <= req_next;
    end
  end

endmodule

// ===== design/dcs_top.sv
// Purpose: command source select and serial link settings of a drive
// Assumes: AXI4-Lite master is the serial link side, panel port is local
// Notes:   station address, rate and protocol change only from the panel
//
// How it works
// - address range depends on protocol, default one
// - address written only from local panel
// - rate codes 0..5 map 300..9600, default 9600
// - rate written only from local panel
// - source codes digital, serial, and, or; default or
// - single-source modes ignore the other source
// - coast is active low, control word bit 3
// - and mode acts only when both ask
// - or mode acts when either asks
// - quick stop active low, control word bit 4
// - quick stop merged like coast
// - dc brake active low, control word bit 2
// - dc brake merged like coast
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`include "dcs_cfg.svh"

module dcs_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // axi write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // axi read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // local operating unit
  input  wire logic        panel_wr,
  input  wire logic [1:0]  panel_sel,
  input  wire logic [7:0]  panel_wdata,
  output logic             panel_ack,
  output logic             panel_nak,
  // terminal inputs, active low
  input  wire logic        coast_in_n,
  input  wire logic        qstop_in_n,
  input  wire logic        dcbrake_in_n,
  // merged commands, active high
  output logic             coast_req,
  output logic             qstop_req,
  output logic             dcbrake_req,
  // link settings
  output logic [7:0]       station_addr,
  output logic [2:0]       line_rate,
  output logic [1:0]       protocol
);

  // settings and state
  logic [15:0]             ctrl_reg;
  logic [5:0]              mode_reg;
  logic [7:0]              addr_reg;
  logic [2:0]              rate_reg;
  logic [1:0]              prot_reg;
  logic [2:0]              din_sync;
  logic [2:0]              cmd_req;
  logic [2:0]              ser_bits;

  // axi slave state
  logic                    aw_got_reg;
  logic                    w_got_reg;
  logic [7:0]              aw_addr_reg;
  logic [31:0]             w_data_reg;
  logic [3:0]              w_strb_reg;
  logic                    bvalid_reg;
  logic [1:0]              bresp_reg;
  logic                    rvalid_reg;
  logic [31:0]             rdata_reg;
  logic [1:0]              rresp_reg;
  logic                    wr_fire;
  logic                    wr_hit;
  logic [31:0]             rd_value;
  logic                    rd_hit;

  // panel side
  logic                    addr_ok;
  logic                    prot_ok;
  logic                    panel_ok;
  logic                    panel_ack_reg;
  logic                    panel_nak_reg;

  // terminal inputs cross into the control clock first
  dcs_sync #(
    .W        (3)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({dcbrake_in_n, qstop_in_n, coast_in_n}),
    .sync_out (din_sync)
  );

  // serial command bits, each active low
  assign ser_bits[0] = ctrl_reg[`DCS_CW_COAST];
  assign ser_bits[1] = ctrl_reg[`DCS_CW_QSTOP];
  assign ser_bits[2] = ctrl_reg[`DCS_CW_DCBRAKE];

  // one merge per command, mode fields packed two bits apart
  for (genvar c = 0; c < 3; c++) begin : g_cmd
    dcs_merge u_merge (
      .aclk    (aclk),
      .aresetn (aresetn),
      .mode    (dcs_pkg::dcs_src_e'(mode_reg[2*c +: 2])),
      .din_n   (din_sync[c]),
      .ser_n   (ser_bits[c]),
      .req     (cmd_req[c])
    );
  end

  assign coast_req   = cmd_req[0];
  assign qstop_req   = cmd_req[1];
  assign dcbrake_req = cmd_req[2];

  // address limits follow the protocol in force
  function automatic logic addr_fits(input logic [1:0] p, input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    unique case (dcs_pkg::dcs_prot_e'(p))
      dcs_pkg::DCS_PROT_NATIVE: ok = (a >= `DCS_NATIVE_MIN) && (a <= `DCS_NATIVE_MAX);
      dcs_pkg::DCS_PROT_BA:     ok = (a >= `DCS_BA_MIN) && (a <= `DCS_BA_MAX);
      dcs_pkg::DCS_PROT_MODBUS: ok = (a >= `DCS_MB_MIN) && (a <= `DCS_MB_MAX);
      dcs_pkg::DCS_PROT_UNUSED: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // a protocol change must keep the present address legal
  assign addr_ok = addr_fits(prot_reg, panel_wdata);
  assign prot_ok = addr_fits(panel_wdata[1:0], addr_reg) && (panel_wdata[7:2] == 6'h00);

  // panel write acceptance
  always_comb begin
    panel_ok = 1'b0;
    if (panel_sel == `DCS_PSEL_ADDR) begin
      panel_ok = addr_ok;
    end else if (panel_sel == `DCS_PSEL_RATE) begin
      panel_ok = (panel_wdata <= {5'h00, `DCS_RATE_MAX});
    end else if (panel_sel == `DCS_PSEL_PROT) begin
      panel_ok = prot_ok;
    end
  end

  // station address, panel only; bus writes never reach it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_reg <= `DCS_RST_ADDR;
    end else if (panel_wr && panel_ok && panel_sel == `DCS_PSEL_ADDR) begin
      addr_reg <= panel_wdata;
    end
  end

  // line rate, panel only; the master has to match it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_reg <= `DCS_RST_RATE;
    end else if (panel_wr && panel_ok && panel_sel == `DCS_PSEL_RATE) begin
      rate_reg <= panel_wdata[2:0];
    end
  end

  // protocol, panel only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prot_reg <= `DCS_RST_PROT;
    end else if (panel_wr && panel_ok && panel_sel == `DCS_PSEL_PROT) begin
      prot_reg <= panel_wdata[1:0];
    end
  end

  // panel answer, one pulse the cycle after the strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      panel_ack_reg <= 1'b0;
      panel_nak_reg <= 1'b0;
    end else begin
      panel_ack_reg <= panel_wr && panel_ok;
      panel_nak_reg <= panel_wr && !panel_ok;
    end
  end

  assign panel_ack    = panel_ack_reg;
  assign panel_nak    = panel_nak_reg;
  assign station_addr = addr_reg;
  assign line_rate    = rate_reg;
  assign protocol     = prot_reg;

  // write channels are caught independently, in either order
  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready  = !w_got_reg && !bvalid_reg;
  assign wr_fire       = aw_got_reg && w_got_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_reg  <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_reg  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_reg  <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_reg  <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got_reg  <= 1'b0;
    end
  end

  // settings offsets answer okay but hold their value
  assign wr_hit = (aw_addr_reg == `DCS_OFF_CTRL) || (aw_addr_reg == `DCS_OFF_MODE) ||
                  (aw_addr_reg == `DCS_OFF_ADDR) || (aw_addr_reg == `DCS_OFF_RATE) ||
                  (aw_addr_reg == `DCS_OFF_PROT) || (aw_addr_reg == `DCS_OFF_STAT);

  // serial control word, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `DCS_RST_CTRL;
    end else if (wr_fire && aw_addr_reg == `DCS_OFF_CTRL) begin
      if (w_strb_reg[0]) begin
        ctrl_reg[7:0] <= w_data_reg[7:0];
      end
      if (w_strb_reg[1]) begin
        ctrl_reg[15:8] <= w_data_reg[15:8];
      end
    end
  end

  // command source modes, all default to or
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= {`DCS_RST_MODE, `DCS_RST_MODE, `DCS_RST_MODE};
    end else if (wr_fire && aw_addr_reg == `DCS_OFF_MODE && w_strb_reg[0]) begin
      mode_reg <= w_data_reg[5:0];
    end
  end

  // write response after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `DCS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // read mux, unmapped reads return zero
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    unique case (s_axi_araddr)
      `DCS_OFF_CTRL: rd_value = {16'h0000, ctrl_reg};
      `DCS_OFF_MODE: rd_value = {26'h000_0000, mode_reg};
      `DCS_OFF_ADDR: rd_value = {24'h00_0000, addr_reg};
      `DCS_OFF_RATE: rd_value = {29'h0000_0000, rate_reg};
      `DCS_OFF_PROT: rd_value = {30'h0000_0000, prot_reg};
      `DCS_OFF_STAT: rd_value = {25'h000_0000, din_sync, 1'b0, cmd_req};
      default:       rd_hit   = 1'b0;
    endcase
  end

  // one read under way at a time
  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `DCS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_value;
      rresp_reg  <= rd_hit ? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

endmodule

// ===== verif/dcs_assertions.sv
// Purpose: concurrent checks on the command source select top
// Assumes: one clock domain, synchronous active-low reset
// Notes:   modes are not visible at the ports, so merge tables are judged in the bench
module dcs_chk (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // local operating unit
  input wire logic       panel_wr,
  input wire logic [1:0] panel_sel,
  input wire logic [7:0] panel_wdata,
  input wire logic       panel_ack,
  input wire logic       panel_nak,
  // commands and settings
  input wire logic       coast_in_n,
  input wire logic       coast_req,
  input wire logic       s_axi_bvalid,
  input wire logic [7:0] station_addr,
  input wire logic [2:0] line_rate,
  input wire logic [1:0] protocol
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // legal rate request, then its effect and answer
  sequence s_rate_cmd;
    panel_wr && panel_sel == 2'h1 && panel_wdata <= 8'h05;
  endsequence
  sequence s_rate_done;
    {5'h00, line_rate} == $past(panel_wdata) && panel_ack && !panel_nak;
  endsequence

  AST_RATE_SET: assert property (s_rate_cmd |=> s_rate_done)
    else $error("panel rate write not applied");
  AST_RATE_LEGAL: assert property (line_rate <= 3'h5)
    else $error("line rate code out of range");
  AST_RATE_HOLD: assert property (!panel_wr |=> $stable(line_rate))
    else $error("line rate moved without panel write");
  AST_ADDR_HOLD: assert property (!panel_wr |=> $stable(station_addr) && $stable(protocol))
    else $error("station address moved without panel write");
  AST_ADDR_RANGE: assert property ((protocol == 2'h0 && station_addr <= 8'hf7) ||
      (protocol == 2'h1 && station_addr >= 8'h01) ||
      (protocol == 2'h3 && station_addr >= 8'h01 && station_addr <= 8'hf7))
    else $error("station address illegal for protocol");
  AST_PANEL_ANSWER: assert property (panel_wr |=> panel_ack != panel_nak)
    else $error("panel write without single answer");
  AST_PANEL_QUIET: assert property (!panel_wr |=> !panel_ack && !panel_nak)
    else $error("panel answer without request");
  // a terminal edge needs two sync flops plus the merge flop, seen one sample later
  AST_REQ_CAUSE: assert property ($changed(coast_req) |-> $past(s_axi_bvalid) || !$past(aresetn, 2) ||
      $past(coast_in_n, 3) != $past(coast_in_n, 4))
    else $error("coast request changed without cause");
endmodule

bind dcs_top dcs_chk chk_u (.aclk, .aresetn, .panel_wr, .panel_sel, .panel_wdata, .panel_ack, .panel_nak,
  .coast_in_n, .coast_req, .s_axi_bvalid, .station_addr, .line_rate, .protocol);

// ===== verif/dcs_master.sv
// Purpose: register bus master standing in for the serial link master
// Assumes: tasks are entered just after a rising edge of aclk
// Notes:   bit timing of the link is not modelled, only its register accesses
module dcs_master (
  // clock
  input  wire logic        aclk,
  // requests
  output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
  output logic [7:0]       s_axi_awaddr, s_axi_araddr,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic [2:0]       s_axi_awprot, s_axi_arprot,
  // answers
  input  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
  input  wire logic [1:0]  s_axi_bresp, s_axi_rresp,
  input  wire logic [31:0] s_axi_rdata
);
  // idle bus; valids, readies and payloads all start at zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {s_axi_awprot, s_axi_arprot} = 6'h00;
  end

  // readies sampled at the falling edge hold for the next rising edge
  // bready and rready stay high between transfers, so no step writes them twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] resp);
    logic pa, pw, ta, tw, tb;
    pa = 1'b1;
    pw = 1'b1;
    tb = 1'b0;
    resp = 2'bxx;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int n = 0; n < 64 && !tb; n++) begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      tb = s_axi_bvalid;
      resp = tb ? s_axi_bresp : resp;
      @(posedge aclk);
      // released address and data show the inverse; the strobes keep their old value
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
        pa = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
        pw = 1'b0;
      end
    end
    // a hung slave ends the run through the bench report
    if (!tb) begin
      dcs_top_bench.n_mismatch++;
      dcs_top_bench.end_sim();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic pa, ta, tr;
    pa = 1'b1;
    tr = 1'b0;
    resp = 2'bxx;
    d = 32'hx;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int n = 0; n < 64 && !tr; n++) begin
      @(negedge aclk);
      ta = pa && s_axi_arready;
      tr = s_axi_rvalid;
      if (tr) {d, resp} = {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ta) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        pa = 1'b0;
      end
    end
    // a hung slave ends the run through the bench report
    if (!tr) begin
      dcs_top_bench.n_mismatch++;
      dcs_top_bench.end_sim();
    end
  endtask
endmodule

// ===== verif/dcs_top_bench.sv
// Purpose: self-checking bench for the command source select top
// Assumes: register bus driven by dcs_master, panel and terminals by the bench
// Notes:   outputs are sampled at the falling edge, clear of update races
`include "dcs_cfg.svh"

module dcs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, panel_wr, panel_ack, panel_nak, coast_in_n, qstop_in_n, dcbrake_in_n;
  logic        coast_req, qstop_req, dcbrake_req, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  panel_sel, s_axi_bresp, s_axi_rresp, protocol;
  logic [2:0]  s_axi_awprot, s_axi_arprot, line_rate;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  panel_wdata, s_axi_awaddr, s_axi_araddr, station_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          n_mismatch, num_checks;

  dcs_top dut_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .panel_wr, .panel_sel, .panel_wdata, .panel_ack, .panel_nak, .coast_in_n,
    .qstop_in_n, .dcbrake_in_n, .coast_req, .qstop_req, .dcbrake_req, .station_addr, .line_rate, .protocol);
  dcs_master m_u (.aclk, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_rready,
    .s_axi_awaddr, .s_axi_araddr, .s_axi_wdata, .s_axi_wstrb, .s_axi_awprot, .s_axi_arprot, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bresp, .s_axi_rresp, .s_axi_rdata);

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one panel strobe, answer and settings seen in the following cycle
  task automatic panel(input logic [1:0] sel, input logic [7:0] wd, input logic ok, input logic [12:0] exp);
    panel_wr <= 1'b1;
    panel_sel <= sel;
    panel_wdata <= wd;
    @(posedge aclk);
    panel_wr <= 1'b0;
    @(negedge aclk);
    chk({panel_ack, panel_nak}, {ok, !ok});
    chk({station_addr, line_rate, protocol}, exp);
    @(posedge aclk);
  endtask

  task automatic t_defaults();
    logic [31:0] d;
    logic [1:0]  r;
    m_u.rd(8'h08, d, r);
    chk(d, 32'h1);
    m_u.rd(8'h0c, d, r);
    chk(d, 32'h5);
    m_u.rd(8'h04, d, r);
    chk(d, 32'h3f);
    chk(r, `DCS_RESP_OKAY);
    @(negedge aclk);
    chk({station_addr, line_rate, protocol, coast_req, qstop_req, dcbrake_req}, 16'h01a7);
    @(posedge aclk);
  endtask

  // address and rate refuse the serial side; unmapped places answer with an error
  task automatic t_serial_locked();
    logic [31:0] d;
    logic [1:0]  r;
    m_u.wr(`DCS_OFF_ADDR, 32'h5, 4'hf, r);
    chk(r, `DCS_RESP_OKAY);
    m_u.wr(`DCS_OFF_RATE, 32'h0, 4'hf, r);
    chk(r, `DCS_RESP_OKAY);
    m_u.wr(8'h18, 32'h0, 4'hf, r);
    chk(r, `DCS_RESP_SLVERR);
    m_u.rd(8'h18, d, r);
    chk(d, 32'h0);
    chk(r, `DCS_RESP_SLVERR);
    @(negedge aclk);
    chk({station_addr, line_rate}, {8'h01, 3'h5});
    @(posedge aclk);
  endtask

  // nibbles: select, value, accepted, address, protocol
  task automatic t_panel();
    logic [27:0] tbl [17] = '{28'h0f71f70, 28'h0f80f70, 28'h0001000, 28'h2010000, 28'h0011010, 28'h2011011,
      28'h0ff1ff1, 28'h0000ff1, 28'h2030ff1, 28'h0f71f71, 28'h2031f73, 28'h0f80f73, 28'h0000f73,
      28'h0011013, 28'h2001010, 28'h2020010, 28'h3000010};
    for (int i = 0; i < 8; i++) panel(2'h1, 8'(i), i < 6, {8'h01, i < 6 ? 3'(i) : 3'h5, 2'h0});
    foreach (tbl[i]) panel(tbl[i][25:24], tbl[i][23:16], tbl[i][12], {tbl[i][11:4], 3'h5, tbl[i][1:0]});
  endtask

  // every command, mode and source combination
  task automatic t_merge();
    int          pos [3] = '{`DCS_CW_COAST, `DCS_CW_QSTOP, `DCS_CW_DCBRAKE};
    logic [31:0] cw;
    logic [2:0]  ins, req;
    logic [1:0]  r;
    logic        din, ser;
    for (int c = 0; c < 3; c++) for (int m = 0; m < 4; m++) for (int v = 0; v < 4; v++) begin
      din = v[1];
      ser = v[0];
      cw = 32'h1c;
      cw[pos[c]] = ser;
      ins = 3'h7;
      ins[2-c] = din;
      {coast_in_n, qstop_in_n, dcbrake_in_n} <= ins;
      m_u.wr(`DCS_OFF_CTRL, cw, 4'h1, r);
      m_u.wr(`DCS_OFF_MODE, {26'h0, {3{m[1:0]}}}, 4'h1, r);
      req = 3'h0;
      req[2-c] = m == 0 ? !din : m == 1 ? !ser : m == 2 ? !din && !ser : !din || !ser;
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      chk({coast_req, qstop_req, dcbrake_req}, req);
      @(posedge aclk);
      // status shows the synchronised terminals above the merged requests
      m_u.rd(`DCS_OFF_STAT, cw, r);
      chk(cw, {25'h0, ins[0], ins[1], ins[2], 1'b0, req[0], req[1], req[2]});
      chk(r, `DCS_RESP_OKAY);
    end
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    {aresetn, panel_wr, panel_sel, panel_wdata} = 12'h0;
    {coast_in_n, qstop_in_n, dcbrake_in_n} = 3'h7;
    n_mismatch = 0;
    num_checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_defaults();
    t_serial_locked();
    t_panel();
    t_merge();
    end_sim();
  end
endmodule
